// [fess_ctrl.sv]
// Purpose: Host sequencer for erase suspend, resume and status polling
// Assumes: Unlock and erase entry sequences are issued with OP_WRITE
// Notes:   Polls give up after a budget; POLL_LIMIT is a parameter, the suspend budget SUSP_CYC a package constant
//
// Contract
// R1: Device accepts suspend only during sector erase or its timeout.
// R2: Suspend during sector timeout ends the timeout and suspends at once.
// R3: While suspended device ignores all but resume and byte program.
// R4: Device reaches suspended state within 15 us of a valid suspend.
// R5: Suspended: ready high, poll bit 1, toggle stops; host reads erasing sector.
// R6: Suspended reads elsewhere give data; suspended sector toggles second bit.
// R7: Suspended program allowed; host polls bit 7 at program address.
// R8: Resume restarts erase; repeat resumes ignored; suspend allowed again.
// R9: Program: poll bit reads inverted bit 7, then true bit 7.
// R10: Erase: poll bit reads 0, then 1 on completion.
// R11: Status valid after 4th, 6th or last sector erase write rising edge.
// R12: Host polls erase status inside an unprotected erasing sector.
// R13: Bit 7 may settle first; host rereads for a fully valid byte.
// R14: Polling status driven only during operations and sector timeout.
// R15: Each read strobe inverts toggle bit while an operation runs.
// R16: Protected program toggles about 2 us, data unchanged.
// R17: All-protected erase toggles about 100 us then returns to read.
// R18: Pulse limit exceeded sets time limit flag; only polling until reset.
// R19: Programming 0 back to 1 never completes; time limit flag set.
// R20: Erase window flag 0 during timeout, 1 once erase begins.
// R21: Host checks window flag before and after each added sector erase.
// R22: Suspended program reads 1 on second toggle bit at program address.
// R23: Each write strobe fall restarts the 50 us sector timeout; model stops it on the fall, rearms it on a sector write rise.
// R24: Ready output high while erase is suspended.
// R25: Toggle bit flips once per read so consecutive reads differ.
`timescale 1ns/1ps
module fess_ctrl #(
  parameter int unsigned POLL_LIMIT = fess_pkg::POLL_CYC
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // User command
  input  wire logic              cmdValid,
  input  wire fess_pkg::fess_op_t cmdOp,
  input  wire logic [20:0]       cmdAddr,
  input  wire logic [7:0]        cmdData,
  output logic                   cmdReady,
  // User response
  output logic                   respValid,
  output fess_pkg::fess_res_t    respResult,
  output logic [7:0]             respData,
  output logic                   eraseSuspended,
  // Flash pins
  output logic [20:0]            flashAddr,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN,
  output logic [7:0]             dataOut,
  output logic                   dataOe,
  input  wire logic [7:0]        dataIn,
  input  wire logic              readyBusy
);

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_WAIT = 2'h1,
    M_RESP = 2'h3
  } fess_mst_t;

  typedef struct packed {
    fess_mst_t           st;
    fess_pkg::fess_op_t  op;
    logic [20:0]         addr;
    logic [7:0]          data;
    logic [7:0]          prev;
    logic [1:0]          phase;
    logic [2:0]          rdCnt;
    logic [23:0]         timer;
    logic                busStart;
    logic                busWrite;
    logic [7:0]          busData;
    logic                suspended;
    logic                respValid;
    fess_pkg::fess_res_t result;
    logic [7:0]          status;
  } fess_ctl_t;

  fess_ctl_t  cur;
  fess_ctl_t  next_cur;
  logic       busDone;
  logic [7:0] busRdata;

  // Toggle bit one moved between two reads
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    return a[fess_pkg::TOGGLE_BIT_ONE] ^ b[fess_pkg::TOGGLE_BIT_ONE];
  endfunction

  function automatic logic overBudget(input logic [23:0] t,
                                      input logic susp);
    return susp ? (t >= 24'(fess_pkg::SUSP_CYC)) : (t >= 24'(POLL_LIMIT));
  endfunction

  always_comb begin
    logic [7:0] r;
    logic       expect7;
    r = busRdata;
    expect7 = (cur.op == fess_pkg::OP_POLL_ERASE) ? 1'b1 : // [R10]
              cur.data[fess_pkg::POLL_BIT];                 // [R9]
    next_cur = cur;
    next_cur.busStart  = 1'b0;
    next_cur.respValid = 1'b0;
    unique case (cur.st)
      M_IDLE: begin
        if (cmdValid) begin
          next_cur.op      = cmdOp;
          next_cur.addr    = cmdAddr;
          next_cur.data    = cmdData;
          next_cur.phase   = 2'h0;
          next_cur.rdCnt   = 3'h0;
          next_cur.timer   = 24'h0;
          next_cur.busData = cmdData;
          next_cur.busWrite = 1'b0;
          next_cur.st      = M_WAIT;
          next_cur.busStart = 1'b1;
          unique case (cmdOp)
            fess_pkg::OP_WRITE: next_cur.busWrite = 1'b1;
            fess_pkg::OP_SUSPEND: begin
              next_cur.busWrite = 1'b1;
              next_cur.busData  = fess_pkg::CMD_SUSPEND;
            end
            fess_pkg::OP_RESUME: begin
              next_cur.busWrite = 1'b1;
              next_cur.busData  = fess_pkg::CMD_RESUME;
            end
            default: next_cur.busWrite = 1'b0;
          endcase
          // Repeat suspends and stray resumes would be ignored anyway
          if ((cmdOp == fess_pkg::OP_SUSPEND && cur.suspended) ||
              (cmdOp == fess_pkg::OP_RESUME && !cur.suspended)) begin // [R8]
            next_cur.busStart = 1'b0;
            next_cur.st       = M_RESP;
            next_cur.respValid = 1'b1;
            next_cur.result   = fess_pkg::RES_REFUSED;
          end
        end
      end
      M_WAIT: begin
        next_cur.timer = cur.timer + 24'h1;
        if (busDone) begin
          if (!cur.busWrite) begin
            next_cur.status = r;
            next_cur.prev   = r;
            if (cur.rdCnt != 3'h7) begin
              next_cur.rdCnt = cur.rdCnt + 3'h1;
            end
          end
          next_cur.busStart = 1'b1;
          next_cur.busWrite = 1'b0;
          next_cur.st       = M_RESP;
          next_cur.result   = fess_pkg::RES_OK;
          unique case (cur.op)
            fess_pkg::OP_WRITE, fess_pkg::OP_READ: begin
              next_cur.busStart = 1'b0;
            end
            fess_pkg::OP_RESUME: begin
              next_cur.busStart  = 1'b0;
              next_cur.suspended = 1'b0; // [R8]
            end
            fess_pkg::OP_SUSPEND: begin
              next_cur.st = M_WAIT;
              next_cur.timer = (cur.phase == 2'h0) ? 24'h0 : next_cur.timer;
              if (cur.phase != 2'h2) begin
                next_cur.phase = cur.phase + 2'h1;
              end else if (!toggled(cur.prev, r) && readyBusy &&
                           r[fess_pkg::POLL_BIT]) begin // [R5] [R24]
                next_cur.busStart  = 1'b0;
                next_cur.suspended = 1'b1;
                next_cur.st        = M_RESP;
              end else if (overBudget(cur.timer, 1'b1)) begin // [R4]
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                next_cur.result   = fess_pkg::RES_TIMEOUT;
              end
            end
            fess_pkg::OP_POLL_PROG, fess_pkg::OP_POLL_ERASE: begin
              next_cur.st = M_WAIT;
              if (cur.phase == 2'h3) begin // [R13]
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
              end else if (r[fess_pkg::POLL_BIT] == expect7) begin
                next_cur.phase = 2'h3;
              end else if (cur.phase == 2'h2) begin // [R18] [R19]
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                next_cur.result   = fess_pkg::RES_FAIL;
              end else if (r[fess_pkg::TIME_LIMIT_FLAG]) begin
                next_cur.phase = 2'h2;
              end else if (overBudget(cur.timer, 1'b0)) begin
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                next_cur.result   = fess_pkg::RES_TIMEOUT;
              end
            end
            fess_pkg::OP_TOGGLE: begin
              next_cur.st = M_WAIT;
              if (cur.phase == 2'h0) begin
                next_cur.phase = 2'h1;
              end else if (cur.phase == 2'h3) begin // [R13]
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
              end else if (!toggled(cur.prev, r)) begin // [R15] [R25]
                next_cur.phase = 2'h3;
              end else if (cur.phase == 2'h2) begin // [R19]
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                next_cur.result   = fess_pkg::RES_FAIL;
              end else if (r[fess_pkg::TIME_LIMIT_FLAG]) begin // [R18]
                next_cur.phase = 2'h2;
              end else if (overBudget(cur.timer, 1'b0)) begin
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                next_cur.result   = fess_pkg::RES_TIMEOUT;
              end
            end
            fess_pkg::OP_ADD_SECTOR: begin
              next_cur.st = M_WAIT;
              if (cur.phase == 2'h0) begin
                if (r[fess_pkg::ERASE_WINDOW_FLAG]) begin // [R20] [R21]
                  next_cur.busStart = 1'b0;
                  next_cur.st       = M_RESP;
                  next_cur.result   = fess_pkg::RES_REFUSED;
                end else begin
                  next_cur.busWrite = 1'b1;
                  next_cur.busData  = fess_pkg::CMD_SECTOR;
                  next_cur.phase    = 2'h1;
                end
              end else if (cur.phase == 2'h1) begin
                next_cur.phase = 2'h2;
              end else begin
                next_cur.busStart = 1'b0;
                next_cur.st       = M_RESP;
                if (r[fess_pkg::ERASE_WINDOW_FLAG]) begin // [R21]
                  next_cur.result = fess_pkg::RES_REJECTED;
                end
              end
            end
          endcase
          next_cur.respValid = (next_cur.st == M_RESP);
        end
      end
      M_RESP: next_cur.st = M_IDLE;
      default: next_cur.st = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{st: M_IDLE, op: fess_pkg::OP_WRITE, addr: 21'h0,
               data: 8'h00, prev: 8'h00, phase: 2'h0, rdCnt: 3'h0,
               timer: 24'h0, busStart: 1'b0, busWrite: 1'b0,
               busData: 8'h00, suspended: 1'b0, respValid: 1'b0,
               result: fess_pkg::RES_OK, status: 8'h00};
    end else begin
      cur <= next_cur;
    end
  end

  // Address held for the whole op keeps polling inside the chosen byte
  fess_bus_cycle u_bus (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (cur.busStart),
    .isWrite   (cur.busWrite),
    .reqAddr   (cur.addr),
    .reqData   (cur.busData),
    .done      (busDone),
    .rdata     (busRdata),
    .flashAddr (flashAddr),
    .flashCeN  (flashCeN),
    .flashOeN  (flashOeN),
    .flashWeN  (flashWeN),
    .dataOut   (dataOut),
    .dataOe    (dataOe),
    .dataIn    (dataIn)
  );

  assign cmdReady       = (cur.st == M_IDLE);
  assign respValid      = cur.respValid;
  assign respResult     = cur.result;
  assign respData       = cur.status;
  assign eraseSuspended = cur.suspended;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_SUSPEND_SEEN: assert property ( // [R5]
    respValid && cur.op == fess_pkg::OP_SUSPEND &&
    respResult == fess_pkg::RES_OK |-> respData[7] && eraseSuspended)
    else $error("Suspend confirmed without poll bit high");
  AST_PROG_POLL_ADDR: assert property ( // [R7]
    cur.st == M_IDLE || !(cur.op == fess_pkg::OP_POLL_PROG
    && !flashCeN) || flashAddr == cur.addr)
    else $error("Program poll left the program address");
  AST_ERASE_POLL_ADDR: assert property ( // [R12]
    $fell(flashOeN) && cur.op == fess_pkg::OP_POLL_ERASE |->
    flashAddr == cur.addr && flashWeN ##1 flashAddr == cur.addr)
    else $error("Erase poll read outside the erasing address");
  AST_REREAD: assert property ( // [R13]
    respValid && respResult == fess_pkg::RES_OK &&
    (cur.op == fess_pkg::OP_POLL_PROG || cur.op == fess_pkg::OP_TOGGLE ||
     cur.op == fess_pkg::OP_POLL_ERASE) |-> cur.rdCnt >= 3'h2)
    else $error("Poll finished without a confirming reread");
  AST_WINDOW_TWICE: assert property ( // [R21]
    respValid && cur.op == fess_pkg::OP_ADD_SECTOR &&
    respResult != fess_pkg::RES_REFUSED |-> cur.rdCnt == 3'h2 ##1 cmdReady)
    else $error("Window flag not checked before and after");

  COV_SUSPEND: cover property (respValid && cur.op == fess_pkg::OP_SUSPEND
    && respResult == fess_pkg::RES_OK);
  COV_POLL_FAIL: cover property (respValid &&
    respResult == fess_pkg::RES_FAIL);
  COV_REJECT: cover property (respValid &&
    respResult == fess_pkg::RES_REJECTED);

endmodule

// [fess_pkg.sv]
// Purpose: Shared constants and types of the flash suspend and status host
// Assumes: 25 MHz ref_clk, byte-wide parallel flash on the far side
// Notes:   Status bit positions follow the flash data_lines layout
package fess_pkg;

  localparam int unsigned CLK_NS        = 40;
  localparam int unsigned WE_LOW_NS     = 80;
  localparam int unsigned OE_ACCESS_NS  = 160;
  localparam int unsigned SUSP_MAX_US   = 15;
  localparam int unsigned POLL_LIMIT_US = 100000;

  // Least times round up, longest times round down
  localparam int unsigned WE_CYC   = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OE_CYC   = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SUSP_CYC = SUSP_MAX_US * 1000 / CLK_NS;
  localparam int unsigned POLL_CYC = POLL_LIMIT_US * 1000 / CLK_NS;

  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME  = 8'h30;
  localparam logic [7:0] CMD_SECTOR  = 8'h30;

  localparam int unsigned POLL_BIT          = 7;
  localparam int unsigned TOGGLE_BIT_ONE    = 6;
  localparam int unsigned TIME_LIMIT_FLAG   = 5;
  localparam int unsigned ERASE_WINDOW_FLAG = 3;
  localparam int unsigned TOGGLE_BIT_TWO    = 2;

  typedef enum logic [2:0] {
    OP_WRITE      = 3'h0,
    OP_READ       = 3'h1,
    OP_SUSPEND    = 3'h2,
    OP_RESUME     = 3'h3,
    OP_POLL_PROG  = 3'h4,
    OP_POLL_ERASE = 3'h5,
    OP_TOGGLE     = 3'h6,
    OP_ADD_SECTOR = 3'h7
  } fess_op_t;

  typedef enum logic [2:0] {
    RES_OK       = 3'h0,
    RES_FAIL     = 3'h1,
    RES_TIMEOUT  = 3'h2,
    RES_REFUSED  = 3'h3,
    RES_REJECTED = 3'h4
  } fess_res_t;

endpackage

// [fess_bus_cycle.sv]
// Purpose: One read or write cycle on the flash strobe pins
// Assumes: start is a one-cycle pulse taken only while idle
// Notes:   Write data is held one cycle past the write strobe rising edge
`timescale 1ns/1ps
module fess_bus_cycle (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [20:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             done,
  output logic [7:0]       rdata,
  // Flash pins
  output logic [20:0]      flashAddr,
  output logic             flashCeN,
  output logic             flashOeN,
  output logic             flashWeN,
  output logic [7:0]       dataOut,
  output logic             dataOe,
  input  wire logic [7:0]  dataIn
);

  typedef enum logic [1:0] {
    B_IDLE   = 2'h0,
    B_SETUP  = 2'h1,
    B_STROBE = 2'h3,
    B_RECOV  = 2'h2
  } fess_bst_t;

  typedef struct packed {
    fess_bst_t   st;
    logic [3:0]  cnt;
    logic        write;
    logic [20:0] addr;
    logic [7:0]  wdata;
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic        oe;
    logic [7:0]  rdata;
    logic        done;
  } fess_bus_t;

  fess_bus_t cur;
  fess_bus_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    unique case (cur.st)
      B_IDLE: begin
        if (start) begin
          next_cur.st    = B_SETUP;
          next_cur.write = isWrite;
          next_cur.addr  = reqAddr;
          next_cur.wdata = reqData;
          next_cur.ceN   = 1'b0;
          next_cur.oe    = isWrite;
        end
      end
      B_SETUP: begin
        next_cur.st  = B_STROBE;
        next_cur.cnt = 4'h0;
        next_cur.weN = ~cur.write;
        next_cur.oeN = cur.write;
      end
      B_STROBE: begin
        next_cur.cnt = cur.cnt + 4'h1;
        if (cur.cnt == 4'((cur.write ? fess_pkg::WE_CYC
                                     : fess_pkg::OE_CYC) - 1)) begin
          next_cur.st  = B_RECOV;
          next_cur.weN = 1'b1;
          next_cur.oeN = 1'b1;
          next_cur.ceN = 1'b1;
          if (!cur.write) begin
            next_cur.rdata = dataIn;
          end
        end
      end
      B_RECOV: begin
        next_cur.st   = B_IDLE;
        next_cur.oe   = 1'b0;
        next_cur.done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{st: B_IDLE, cnt: 4'h0, write: 1'b0, addr: 21'h0,
               wdata: 8'h00, ceN: 1'b1, oeN: 1'b1, weN: 1'b1, oe: 1'b0,
               rdata: 8'h00, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign done      = cur.done;
  assign rdata     = cur.rdata;
  assign flashAddr = cur.addr;
  assign flashCeN  = cur.ceN;
  assign flashOeN  = cur.oeN;
  assign flashWeN  = cur.weN;
  assign dataOut   = cur.wdata;
  assign dataOe    = cur.oe;

endmodule

// [fess_flash_model.sv]
// Purpose: Behavioural byte-wide flash seen by the host sequencer
// Assumes: Times in ns, shortened by parameters for simulation
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module fess_flash_model #(
  parameter int          TOUT_NS  = 50000,
  parameter int          ERASE_NS = 6000,
  parameter int          CHIP_NS  = 20000,
  parameter int          SUSP_NS  = 2000,
  parameter int          PROG_NS  = 1000,
  parameter int          PROT_NS  = 2000,
  parameter int          LIMIT_NS = 3000,
  parameter logic [31:0] PROT     = 32'h0000_0040,
  parameter logic [31:0] BLANK    = 32'h0000_ff00
) (
  // Host strobes
  input  wire logic [20:0] flashAddr,
  input  wire logic        flashCeN,
  input  wire logic        flashOeN,
  input  wire logic        flashWeN,
  // Data lines and ready pin
  input  wire logic [7:0]  dataOut,
  input  wire logic        dataOe,
  output logic [7:0]       dataIn,
  output logic             readyBusy
);
  localparam int RD = 0, TOUT = 1, ERS = 2, SUSP = 3, PRG = 4, CHIP = 5;
  localparam int FAIL = 6;
  int          mode = RD, back = RD, gen = 0, seq = 0;
  logic        setup = 1'b0, progArm = 1'b0, drv = 1'b0, d7 = 1'b0;
  logic        tog1 = 1'b0, tog2 = 1'b0, busy, inSec, ws;
  logic [31:0] esecs = '0, blank = BLANK;
  logic [7:0]  q = 8'h00;
  logic [7:0]  mem [int];

  assign busy      = mode != RD && mode != SUSP;
  assign readyBusy = !busy;  // Open drain, pulled high
  assign inSec     = esecs[flashAddr[20:16]];
  assign dataIn    = dataOe ? dataOut : (drv ? q : ~q);

  function automatic logic [7:0] arr(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : (blank[a[20:16]] ? 8'hff : 8'h00);
  endfunction

  // A newer generation cancels any older pending timer
  task automatic arm(input int ns, input int nm);
    int g;
    gen++;
    g = gen;
    fork
      begin
        #(ns);
        if (g == gen) mode = nm;
      end
    join_none
  endtask

  always @(mode) begin
    if (mode == ERS) arm(ERASE_NS, RD);
    if (mode == RD) begin
      blank = blank | (esecs & ~PROT);  // Protected sectors kept
      esecs = '0;
    end
  end

  always @(flashCeN or flashOeN) begin
    if (!flashCeN && !flashOeN && !drv) begin
      drv = 1'b1;
      case (mode)
        TOUT, ERS, CHIP:
          q = {1'b0, tog1, 2'b00, mode != TOUT, tog2, 2'b00};
        SUSP:
          q = inSec ? {4'hc, 1'b1, tog2, 2'b00} : arr(flashAddr);
        PRG, FAIL:
          q = {~d7, tog1, mode == FAIL, 1'b0, back == SUSP,
               (back == SUSP && inSec) ? tog2 : 1'b1, 2'b00};
        default: q = arr(flashAddr);
      endcase
    end else if (drv && (flashCeN || flashOeN)) begin
      drv = 1'b0;
      if (busy) tog1 = ~tog1;
      if (inSec) tog2 = ~tog2;
    end
  end

  task automatic burn(input logic [20:0] a, input logic [7:0] d);
    back = mode;
    d7 = d[7];
    mode = PRG;
    if (PROT[a[20:16]]) arm(PROT_NS, back);
    else if ((arr(a) & d) != d) arm(LIMIT_NS, FAIL);
    else begin
      mem[a] = d;
      arm(PROG_NS, back);
    end
  endtask

  task automatic command(input logic [20:0] a, input logic [7:0] d);
    if (mode == FAIL) begin
      if (d == 8'hf0) mode = RD;  // Only a reset leaves
    end else if (progArm) begin
      progArm = 1'b0;
      burn(a, d);
    end else if (d == 8'hb0) begin  // Address ignored
      if (mode == TOUT) begin
        gen++;
        mode = SUSP;
      end else if (mode == ERS) arm(SUSP_NS, SUSP);
    end else if (d == 8'h30 && mode == SUSP) mode = ERS;
    else if (d == 8'h30 && mode == TOUT) begin
      esecs[a[20:16]] = 1'b1;
      arm(TOUT_NS, ERS);
    end else if (mode == RD || mode == SUSP) begin
      if (d == 8'haa) seq = 1;
      else if (d == 8'h55 && seq == 1) seq = 2;
      else if (seq == 2 && d == 8'ha0) progArm = 1'b1;
      else if (seq == 2 && d == 8'h80 && mode == RD) setup = 1'b1;
      else if (seq == 2 && setup && d == 8'h10) begin
        setup = 1'b0;
        esecs = '1;
        mode = CHIP;
        arm(CHIP_NS, RD);
      end else if (seq == 2 && setup && d == 8'h30) begin
        setup = 1'b0;
        esecs[a[20:16]] = 1'b1;
        mode = TOUT;
        arm(TOUT_NS, ERS);
      end
      if (d != 8'haa && d != 8'h55) seq = 0;
    end
  endtask

  // Timer cancelled on the falling strobe, rearmed on the rise
  always @(negedge flashWeN) begin
    ws = !flashCeN;
    if (ws && mode == TOUT) gen++;
  end
  always @(posedge flashWeN) if (ws) command(flashAddr, dataOut);
endmodule

// [test_fess_ctrl.sv]
// Purpose: Self-checking bench for the flash suspend and status host
// Assumes: Flash model with shortened timers on the far side
// Notes:   Rows hold ordinary cases; toggling and reset checked by hand
`timescale 1ns/1ps
module test_fess_ctrl;
  localparam fess_pkg::fess_op_t  W = fess_pkg::OP_WRITE;
  localparam fess_pkg::fess_op_t  R = fess_pkg::OP_READ;
  localparam fess_pkg::fess_op_t  S = fess_pkg::OP_SUSPEND;
  localparam fess_pkg::fess_op_t  U = fess_pkg::OP_RESUME;
  localparam fess_pkg::fess_op_t  PP = fess_pkg::OP_POLL_PROG;
  localparam fess_pkg::fess_op_t  PE = fess_pkg::OP_POLL_ERASE;
  localparam fess_pkg::fess_op_t  AS = fess_pkg::OP_ADD_SECTOR;
  localparam fess_pkg::fess_res_t OK = fess_pkg::RES_OK;
  localparam fess_pkg::fess_res_t FL = fess_pkg::RES_FAIL;
  localparam fess_pkg::fess_res_t TO = fess_pkg::RES_TIMEOUT;
  localparam fess_pkg::fess_res_t RF = fess_pkg::RES_REFUSED;
  typedef struct {
    int                  pre;
    fess_pkg::fess_op_t  op;
    logic [20:0]         addr;
    logic [7:0]          data;
    fess_pkg::fess_res_t res;
    logic [7:0]          mask;
    logic [7:0]          exp;
    logic                susp;
  } fess_row_t;

  logic                ref_clk = 1'b0, rst_n = 1'b0, cmdValid = 1'b0;
  fess_pkg::fess_op_t  cmdOp = fess_pkg::OP_READ;
  logic [20:0]         cmdAddr = 21'h000000, flashAddr;
  logic [7:0]          cmdData = 8'h00, dataOut, dataIn, respData, v;
  logic                cmdReady, respValid, eraseSuspended, flashCeN;
  logic                flashOeN, flashWeN, dataOe, readyBusy;
  fess_pkg::fess_res_t respResult;
  int                  errCount = 0, checkCount = 0;

  // Pre: 1 program unlock, 2 erase unlock
  fess_row_t rows [23] = '{
    '{2, W, 21'h030010, 8'h30, OK, 8'h00, 8'h00, 1'b0},
    '{0, AS, 21'h040000, 8'h30, OK, 8'h08, 8'h00, 1'b0},
    '{0, S, 21'h030000, 8'h00, OK, 8'hf8, 8'hc8, 1'b1},
    '{0, S, 21'h030000, 8'h00, RF, 8'h00, 8'h00, 1'b1},
    '{0, R, 21'h050100, 8'h00, OK, 8'hff, 8'h00, 1'b1},
    '{1, W, 21'h090020, 8'ha5, OK, 8'h00, 8'h00, 1'b1},
    '{0, PP, 21'h090020, 8'ha5, OK, 8'hff, 8'ha5, 1'b1},
    '{0, U, 21'h030000, 8'h00, OK, 8'h00, 8'h00, 1'b0},
    '{0, S, 21'h030000, 8'h00, OK, 8'hf8, 8'hc8, 1'b1},
    '{0, U, 21'h030000, 8'h00, OK, 8'h00, 8'h00, 1'b0},
    '{0, PE, 21'h030000, 8'h00, OK, 8'hff, 8'hff, 1'b0},
    '{0, R, 21'h040000, 8'h00, OK, 8'hff, 8'hff, 1'b0},
    '{1, W, 21'h050100, 8'h80, OK, 8'h00, 8'h00, 1'b0},
    '{0, PP, 21'h050100, 8'h80, FL, 8'ha0, 8'h20, 1'b0},
    '{0, W, 21'h000000, 8'hf0, OK, 8'h00, 8'h00, 1'b0},
    '{0, R, 21'h050100, 8'h00, OK, 8'hff, 8'h00, 1'b0},
    '{2, W, 21'h005555, 8'h10, OK, 8'h00, 8'h00, 1'b0},
    '{0, S, 21'h000000, 8'h00, TO, 8'h00, 8'h00, 1'b0},
    '{0, PE, 21'h000000, 8'h00, OK, 8'hff, 8'hff, 1'b0},
    '{1, W, 21'h060000, 8'ha5, OK, 8'h00, 8'h00, 1'b0},
    '{0, fess_pkg::OP_TOGGLE, 21'h060000, 8'ha5, OK, 8'hff, 8'h00, 1'b0},
    '{0, R, 21'h060000, 8'h00, OK, 8'hff, 8'h00, 1'b0},
    '{0, U, 21'h000000, 8'h00, RF, 8'h00, 8'h00, 1'b0}};

  fess_ctrl #(.POLL_LIMIT(4000)) fess_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .respValid(respValid), .respResult(respResult), .respData(respData),
    .eraseSuspended(eraseSuspended), .flashAddr(flashAddr),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .readyBusy(readyBusy));
  fess_flash_model #(.TOUT_NS(2000)) fess_flash_model_inst (
    .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .dataOut(dataOut), .dataOe(dataOe),
    .dataIn(dataIn), .readyBusy(readyBusy));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held from one falling edge to the next; one take edge between
  task automatic do_op(input fess_pkg::fess_op_t op, input logic [20:0] a,
                       input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmdReady !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    n = 0;
    while (respValid !== 1'b1 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 6000) errCount++;
  endtask

  task automatic prefix(input int kind);
    do_op(W, 21'h005555, 8'haa);
    do_op(W, 21'h002aaa, 8'h55);
    do_op(W, 21'h005555, kind == 1 ? 8'ha0 : 8'h80);
    if (kind == 2) begin
      do_op(W, 21'h005555, 8'haa);
      do_op(W, 21'h002aaa, 8'h55);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under 20000 cycles
  initial begin
    #2000000;
    errCount++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].pre != 0) prefix(rows[i].pre);
      do_op(rows[i].op, rows[i].addr, rows[i].data);
      chk(8'(respResult), 8'(rows[i].res));
      chk(respData & rows[i].mask, rows[i].exp);
      chk(8'(eraseSuspended), 8'(rows[i].susp));
      $display("row %0d done", i);
    end
    // Fresh erase: both toggle bits move on every read
    prefix(2);
    do_op(W, 21'h0a0000, 8'h30);
    do_op(R, 21'h0a0000, 8'h00);
    v = respData;
    do_op(R, 21'h0a0000, 8'h00);
    chk((v ^ respData) & 8'h44, 8'h44);
    chk(respData & 8'h88, 8'h00);
    $display("toggle test done");
    do_op(S, 21'h0a0000, 8'h00);
    do_op(R, 21'h0a0000, 8'h00);
    v = respData;
    do_op(R, 21'h0a0000, 8'h00);
    chk((v ^ respData) & 8'h44, 8'h04);
    $display("suspended read test done");
    // Mid-run reset while suspended idles pins and clears the flag
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk({cmdReady, respValid, eraseSuspended, flashWeN, dataOe},
        8'h12);
    rst_n = 1'b1;
    do_op(U, 21'h0a0000, 8'h00);
    chk(8'(respResult), 8'(RF));
    $display("reset test done");
    tally_and_finish();
  end
endmodule
